// ==== rtl/cdpwm_core.sv ====
`timescale 1ns/1ps
//
// Contract
// - Mode input high means charge, low means discharge.
// - Mode is captured when enable rises and held while the run gate stays high.
// - Mode is captured again when the fault input is released.
// - A new mode is accepted only while switching is disabled.
// - Charge is buck with high side leading; discharge boost, low first.
// - Enable low stops switching and holds both drives low.
// - Thermal, undervoltage or external fault also stop switching.
// - Supply lockout clears at the upper level, sets below the lower.
// - Enable rising starts a fresh ramp from zero.
// - Off below low level, leading side only, both above high level.
// - Duty cycle is limited in proportion to the ramp.
// - Dead time keeps the two drives from switching together.
// - Current limit ends the main pulse and pulls the flag low.
// - More than sixteen consecutive limited cycles means overload.
// - A cycle without limit clears the overload counter.
// - Overload zeroes the ramp and blocks drives for sixteen cycles.
// - After the cool-down switching restarts with a new ramp.
// - Limit comparator polarity follows the latched mode.
// - Sync switch turns off when current enters the zero window.
// - Fault low holds drives low and discharges the ramp.
// - Thermal shutdown holds drives low and resets the ramp.
//
module cdpwm_core
    import cdpwm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Pins and comparators
    input  cdpwm_pins_t      pins_i,
    // Drive outputs
    output logic             high_side_drive_o,
    output logic             low_side_drive_o,
    output logic             current_limit_flag_n_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cdpwm_cfg_t   cfg_q;
    cdpwm_stage_t stage_q;
    logic [31:0]  rdata_q;
    logic [31:0]  rdata_d;
    logic [31:0]  wmerge;
    logic         wait_q;
    logic         wr_go;
    logic         lockout_q;
    logic         run;
    logic         run_q;
    logic         mode_q;
    logic [15:0]  ph_q;
    logic [15:0]  pm1;
    logic         cyc_end;
    logic [7:0]   ss_q;
    logic [7:0]   sdiv_q;
    logic         lim_sel;
    logic         lim_hit;
    logic         lim_q;
    logic         cyc_lim;
    logic         flag_n_q;
    logic [4:0]   ocnt_q;
    logic [4:0]   cool_q;
    logic         ovl_now;
    logic         zc_q;
    logic [15:0]  duty_t;
    logic [15:0]  ss_t;
    logic [15:0]  on_t;
    logic         active;
    logic         main_req;
    logic         sync_req;
    logic         hs_req;
    logic         ls_req;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    always_comb begin
        case (avs_address_i)
            CDPWM_OFS_PERIOD: rdata_d = {16'h0000, cfg_q.period};
            CDPWM_OFS_DUTY:   rdata_d = {24'h000000, cfg_q.duty};
            CDPWM_OFS_DEAD:   rdata_d = {24'h000000, cfg_q.dead_time_set};
            CDPWM_OFS_SS:     rdata_d = {8'h00, cfg_q.ss_hi, cfg_q.ss_lo,
                                         cfg_q.ss_div};
            CDPWM_OFS_STATUS: begin
                rdata_d = 32'h00000000;
                rdata_d[CDPWM_ST_RUN]   = run_q;
                rdata_d[CDPWM_ST_MODE]  = mode_q;
                rdata_d[CDPWM_ST_COOL]  = (stage_q == CDPWM_COOL);
                rdata_d[CDPWM_ST_SUPPLY_UNDERVOLTAGE_LOCKOUT]  = lockout_q;
                rdata_d[CDPWM_ST_NSYNC] = (stage_q == CDPWM_NSYNC);
                rdata_d[CDPWM_ST_SYNC]  = (stage_q == CDPWM_SYNC);
                rdata_d[CDPWM_ST_SS_LSB +: 8] = ss_q;
            end
            default:          rdata_d = 32'h00000000;
        endcase
    end

    assign wmerge = cdpwm_merge(rdata_d, avs_writedata_i, avs_byteenable_i);
    assign wr_go  = avs_write_i && !wait_q;

    // One wait cycle per access; the access completes at the edge
    // where the master sees waitrequest low.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else if (ce_i) begin
            if ((avs_read_i || avs_write_i) && wait_q) begin
                wait_q  <= 1'b0;
                rdata_q <= avs_read_i ? rdata_d : 32'h00000000;
            end else begin
                wait_q  <= 1'b1;
            end
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_q.period        <= CDPWM_PERIOD_RST;
            cfg_q.duty          <= CDPWM_DUTY_RST;
            cfg_q.dead_time_set <= CDPWM_DEAD_RST;
            cfg_q.ss_div        <= CDPWM_SSDIV_RST;
            cfg_q.ss_lo         <= CDPWM_SSLO_RST;
            cfg_q.ss_hi         <= CDPWM_SSHI_RST;
        end else if (ce_i && wr_go) begin
            case (avs_address_i)
                CDPWM_OFS_PERIOD: cfg_q.period        <= wmerge[15:0];
                CDPWM_OFS_DUTY:   cfg_q.duty          <= wmerge[7:0];
                CDPWM_OFS_DEAD:   cfg_q.dead_time_set <= wmerge[7:0];
                CDPWM_OFS_SS: begin
                    cfg_q.ss_div <= wmerge[CDPWM_SS_DIV_LSB +: 8];
                    cfg_q.ss_lo  <= wmerge[CDPWM_SS_LO_LSB +: 8];
                    cfg_q.ss_hi  <= wmerge[CDPWM_SS_HI_LSB +: 8];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Gating and mode latch
    // ------------------------------------------------------------
    // The supply comparators carry no hysteresis of their own, so the
    // gap between the two thresholds is held here.
    // lockout hysteresis
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            lockout_q <= 1'b1;
        end else if (ce_i) begin
            if (pins_i.supply_above_on) begin
                lockout_q <= 1'b0;
            end else if (!pins_i.supply_above_off) begin
                lockout_q <= 1'b1;
            end
        end
    end

    assign run = pins_i.enable && pins_i.fault_n && !lockout_q
              && !pins_i.thermal_shutdown;

    // Capturing on the rise of the whole gate covers enable, fault
    // release and recovery from lockout or thermal shutdown alike.
    // mode capture
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            run_q  <= 1'b0;
            mode_q <= 1'b0;
        end else if (ce_i) begin
            run_q <= run;
            if (run && !run_q) begin
                mode_q <= pins_i.mode;
            end
        end
    end

    // ------------------------------------------------------------
    // Switching cycle and soft start
    // ------------------------------------------------------------
    assign pm1     = (cfg_q.period == 16'h0000) ? 16'h0000
                                                : cfg_q.period - 16'h0001;
    assign cyc_end = run && (ph_q >= pm1);

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ph_q <= 16'h0000;
        end else if (ce_i) begin
            ph_q <= (!run || cyc_end) ? 16'h0000 : ph_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ss_q   <= 8'h00;
            sdiv_q <= 8'h00;
        end else if (ce_i) begin
            if (!run || ovl_now || stage_q == CDPWM_COOL) begin
                ss_q   <= 8'h00;
                sdiv_q <= 8'h00;
            end else if (sdiv_q >= cfg_q.ss_div) begin
                sdiv_q <= 8'h00;
                if (ss_q != CDPWM_SS_TOP) begin
                    ss_q <= ss_q + 8'h01;
                end
            end else begin
                sdiv_q <= sdiv_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Peak current limit and overload
    // ------------------------------------------------------------
    // sense polarity
    assign lim_sel = mode_q ? pins_i.limit_pos : pins_i.limit_neg;
    assign lim_hit = active && lim_sel;
    assign cyc_lim = lim_q || lim_hit;
    assign ovl_now = cyc_end && cyc_lim && (ocnt_q >= CDPWM_OVL_LIMIT);

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            lim_q    <= 1'b0;
            flag_n_q <= 1'b1;
        end else if (ce_i) begin
            lim_q    <= (cyc_end || !run) ? 1'b0 : cyc_lim;
            flag_n_q <= !lim_hit && !(lim_q && !cyc_end && run);
        end
    end

    assign current_limit_flag_n_o = flag_n_q;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ocnt_q <= 5'h00;
        end else if (ce_i) begin
            if (!run || ovl_now) begin
                ocnt_q <= 5'h00;
            end else if (cyc_end) begin
                ocnt_q <= cyc_lim ? ocnt_q + 5'h01 : 5'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Stage control
    // ------------------------------------------------------------
    // stages
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            stage_q <= CDPWM_OFF;
            cool_q  <= 5'h00;
        end else if (ce_i) begin
            if (!run) begin
                stage_q <= CDPWM_OFF;
                cool_q  <= 5'h00;
            end else if (ovl_now) begin
                stage_q <= CDPWM_COOL;
                cool_q  <= CDPWM_COOL_CYC;
            end else begin
                case (stage_q)
                    CDPWM_COOL: begin
                        if (cyc_end) begin
                            cool_q <= cool_q - 5'h01;
                            if (cool_q == 5'h01) begin
                                stage_q <= CDPWM_OFF;
                            end
                        end
                    end
                    default: begin
                        if (ss_q > cfg_q.ss_hi) begin
                            stage_q <= CDPWM_SYNC;
                        end else if (ss_q > cfg_q.ss_lo) begin
                            stage_q <= CDPWM_NSYNC;
                        end else begin
                            stage_q <= CDPWM_OFF;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Pulse requests
    // ------------------------------------------------------------
    // ramp duty clamp
    assign duty_t = cdpwm_scale(cfg_q.duty, cfg_q.period);
    assign ss_t   = cdpwm_scale(ss_q, cfg_q.period);
    assign on_t   = (ss_t < duty_t) ? ss_t : duty_t;
    assign active = run && (stage_q == CDPWM_NSYNC || stage_q == CDPWM_SYNC);

    assign main_req = active && (ph_q < on_t) && !lim_q && !lim_hit;

    // Once current has reached zero the sync switch stays off for the
    // rest of the cycle, which is what a diode would do.
    // zero window latch
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            zc_q <= 1'b0;
        end else if (ce_i) begin
            zc_q <= (cyc_end || !run) ? 1'b0 : (zc_q || pins_i.zero_current);
        end
    end

    assign sync_req = run && stage_q == CDPWM_SYNC && (ph_q >= on_t)
                   && !zc_q && !pins_i.zero_current;

    assign hs_req = mode_q ? main_req : sync_req;
    assign ls_req = mode_q ? sync_req : main_req;

    cdpwm_dead u_dead (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .hs_req_i  (hs_req),
        .ls_req_i  (ls_req),
        .dead_i    (cfg_q.dead_time_set),
        .hs_o      (high_side_drive_o),
        .ls_o      (low_side_drive_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mode_hold;
        @(posedge clk_sys_i) disable iff (reset_i)
        ce_i && run && run_q |=> mode_q == $past(mode_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");

    property p_mode_cap;
        @(posedge clk_sys_i) disable iff (reset_i)
        ce_i && run && !run_q |=> mode_q == $past(pins_i.mode);
    endproperty
    a_mode_cap: assert property (p_mode_cap) else $error("mode not taken");

    property p_off;
        @(posedge clk_sys_i) disable iff (reset_i)
        ce_i && !run |=> !high_side_drive_o && !low_side_drive_o;
    endproperty
    a_off: assert property (p_off) else $error("drive while disabled");

    property p_lockout;
        @(posedge clk_sys_i) disable iff (reset_i)
        ce_i && lockout_q && !pins_i.supply_above_on |=> lockout_q;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout left early");

    property p_nsync;
        @(posedge clk_sys_i) disable iff (reset_i)
        ce_i && stage_q != CDPWM_SYNC
        |=> !(mode_q ? low_side_drive_o : high_side_drive_o);
    endproperty
    a_nsync: assert property (p_nsync) else $error("sync too early");

    property p_flag;
        @(posedge clk_sys_i) disable iff (reset_i)
        ce_i && lim_hit |=> !current_limit_flag_n_o;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not low");

    property p_ovl;
        @(posedge clk_sys_i) disable iff (reset_i)
        ce_i && run && cyc_end && cyc_lim && ocnt_q == CDPWM_OVL_LIMIT
        |=> stage_q == CDPWM_COOL && cool_q == CDPWM_COOL_CYC;
    endproperty
    a_ovl: assert property (p_ovl) else $error("overload missed");

    property p_clear;
        @(posedge clk_sys_i) disable iff (reset_i)
        ce_i && cyc_end && !cyc_lim |=> ocnt_q == 5'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("count not cleared");

    property p_cool;
        @(posedge clk_sys_i) disable iff (reset_i)
        ce_i && stage_q == CDPWM_COOL
        |=> ss_q == 8'h00 && !high_side_drive_o && !low_side_drive_o;
    endproperty
    a_cool: assert property (p_cool) else $error("switching in cool-down");

endmodule : cdpwm_core

// ==== rtl/cdpwm_dead.sv ====
`timescale 1ns/1ps
module cdpwm_dead
    import cdpwm_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic       ce_i,
    // Requests and setting
    input  wire logic       hs_req_i,
    input  wire logic       ls_req_i,
    input  wire logic [7:0] dead_i,
    // Drives
    output logic            hs_o,
    output logic            ls_o
);

    logic [7:0] cnt_q;
    logic       hs_q;
    logic       ls_q;
    logic       fall;

    assign hs_o = hs_q;
    assign ls_o = ls_q;
    assign fall = (hs_q && !hs_req_i) || (ls_q && !ls_req_i);

    // ------------------------------------------------------------
    // Dead-time gap
    // ------------------------------------------------------------
    // gap count
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 8'h00;
        end else if (ce_i) begin
            if (fall) begin
                cnt_q <= dead_i;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end

    // A side turns on only after the other has been seen off, so two
    // edges can never land in the same cycle even with a zero setting.
    // staggered edges
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hs_q <= 1'b0;
            ls_q <= 1'b0;
        end else if (ce_i) begin
            hs_q <= hs_q ? hs_req_i
                         : (hs_req_i && !ls_q && !fall && cnt_q == 8'h00);
            ls_q <= ls_q ? ls_req_i
                         : (ls_req_i && !hs_req_i && !hs_q && !fall
                            && cnt_q == 8'h00);
        end
    end

    property p_excl;
        @(posedge clk_sys_i) disable iff (reset_i)
        !(hs_q && ls_q);
    endproperty
    a_excl: assert property (p_excl) else $error("both drives high");

    property p_nosame;
        @(posedge clk_sys_i) disable iff (reset_i)
        !($changed(hs_q) && $changed(ls_q));
    endproperty
    a_nosame: assert property (p_nosame) else $error("drives switched together");

endmodule : cdpwm_dead

// ==== rtl/cdpwm_pkg.sv ====
package cdpwm_pkg;

    // ------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------
    localparam logic [7:0]  CDPWM_OFS_PERIOD = 8'h00;
    localparam logic [7:0]  CDPWM_OFS_DUTY   = 8'h04;
    localparam logic [7:0]  CDPWM_OFS_DEAD   = 8'h08;
    localparam logic [7:0]  CDPWM_OFS_SS     = 8'h0c;
    localparam logic [7:0]  CDPWM_OFS_STATUS = 8'h10;
    localparam int          CDPWM_SS_DIV_LSB = 0;
    localparam int          CDPWM_SS_LO_LSB  = 8;
    localparam int          CDPWM_SS_HI_LSB  = 16;
    localparam int          CDPWM_ST_RUN     = 0;
    localparam int          CDPWM_ST_MODE    = 1;
    localparam int          CDPWM_ST_COOL    = 2;
    localparam int          CDPWM_ST_SUPPLY_UNDERVOLTAGE_LOCKOUT    = 3;
    localparam int          CDPWM_ST_NSYNC   = 4;
    localparam int          CDPWM_ST_SYNC    = 5;
    localparam int          CDPWM_ST_SS_LSB  = 8;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [15:0] CDPWM_PERIOD_RST = 16'h01f4;
    localparam logic [7:0]  CDPWM_DUTY_RST   = 8'h80;
    localparam logic [7:0]  CDPWM_DEAD_RST   = 8'h05;
    localparam logic [7:0]  CDPWM_SSDIV_RST  = 8'h04;
    localparam logic [7:0]  CDPWM_SSLO_RST   = 8'h1b;
    localparam logic [7:0]  CDPWM_SSHI_RST   = 8'he5;
    localparam logic [7:0]  CDPWM_SS_TOP     = 8'hff;
    localparam logic [4:0]  CDPWM_OVL_LIMIT  = 5'h10;
    localparam logic [4:0]  CDPWM_COOL_CYC   = 5'h10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic mode;
        logic fault_n;
        logic supply_above_on;
        logic supply_above_off;
        logic thermal_shutdown;
        logic limit_pos;
        logic limit_neg;
        logic zero_current;
    } cdpwm_pins_t;

    typedef struct packed {
        logic [15:0] period;
        logic [7:0]  duty;
        logic [7:0]  dead_time_set;
        logic [7:0]  ss_div;
        logic [7:0]  ss_lo;
        logic [7:0]  ss_hi;
    } cdpwm_cfg_t;

    typedef enum logic [1:0] {
        CDPWM_OFF   = 2'b00,
        CDPWM_NSYNC = 2'b01,
        CDPWM_SYNC  = 2'b10,
        CDPWM_COOL  = 2'b11
    } cdpwm_stage_t;

    function automatic logic [15:0] cdpwm_scale(input logic [7:0] frac,
                                               input logic [15:0] per);
        logic [23:0] prod;
        prod = frac * per;
        return prod[23:8];
    endfunction : cdpwm_scale

    function automatic logic [31:0] cdpwm_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : cdpwm_merge

endpackage : cdpwm_pkg

// ==== test/cdpwm_core_tb.sv ====
`timescale 1ns/1ps
module cdpwm_core_tb;
    import cdpwm_pkg::*;
    logic clk_sys_i = 0, reset_i = 1, rd = 0, wr = 0, wait_w, hs, ls, flag_n, lp, ln, zc;
    logic en = 0, md = 0, flt_n = 1, von = 1, voff = 1, hot = 0, frc = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat_w, q, v;
    logic [2:0]  off_h = 3'h7;
    int          mismatches = 0, total_checks = 0, k;
    cdpwm_pins_t pins;
    assign pins = '{en, md, flt_n, von, voff, hot, lp, ln, zc};
    cdpwm_core u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat_w), .avs_waitrequest_o(wait_w),
        .pins_i(pins), .high_side_drive_o(hs), .low_side_drive_o(ls),
        .current_limit_flag_n_o(flag_n));
    cdpwm_stage_model u_stage (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hs_i(hs),
        .ls_i(ls), .mode_i(md), .force_i(frc), .limit_pos_o(lp), .limit_neg_o(ln),
        .zero_current_o(zc));
    always #5 clk_sys_i = ~clk_sys_i;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        adr <= a;
        wd  <= d;
        wr  <= w;
        rd  <= !w;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (wait_w !== 1'b0 && k < 20);
        if (wait_w !== 1'b0) begin
            mismatches++;
            close_out();
        end
        q = rdat_w;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task poll(input int b, input logic val);
        int n;
        n = 0;
        do begin
            bus(1'b0, CDPWM_OFS_STATUS, 32'h0);
            n++;
        end while (q[b] !== val && n < 900);
        if (q[b] !== val) begin
            mismatches++;
            close_out();
        end
    endtask : poll

    // ------------------------------------------------------------
    // Drive monitor
    // ------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        off_h <= {off_h[1:0], !(en & flt_n & voff & !hot)};
        if (!reset_i) begin
            check(hs & ls, 32'h0);
            if (&off_h) begin
                check({hs, ls}, 32'h0);
            end
        end
    end

    task run_mode(input logic m);
        @(posedge clk_sys_i);
        md <= m;
        @(posedge clk_sys_i);
        en <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        md <= !m;
        k = 0;
        while (!(hs | ls) && k < 4000) begin
            @(posedge clk_sys_i);
            k++;
        end
        check({hs, ls}, m ? 32'h2 : 32'h1);
        bus(1'b0, CDPWM_OFS_STATUS, 32'h0);
        check(q[CDPWM_ST_MODE], m);
        @(posedge clk_sys_i);
        en <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask : run_mode

    initial begin
        v = $urandom(32'hba9363fa);
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        bus(1'b0, CDPWM_OFS_PERIOD, 32'h0);
        check(q, {16'h0, CDPWM_PERIOD_RST});
        bus(1'b0, CDPWM_OFS_DEAD, 32'h0);
        check(q, {24'h0, CDPWM_DEAD_RST});
        bus(1'b0, CDPWM_OFS_SS, 32'h0);
        check(q, {8'h0, CDPWM_SSHI_RST, CDPWM_SSLO_RST, CDPWM_SSDIV_RST});
        bus(1'b0, 8'h14, 32'h0);
        check(q, 32'h0);
        repeat (4) begin
            v = $urandom;
            bus(1'b1, CDPWM_OFS_DUTY, v);
            bus(1'b0, CDPWM_OFS_DUTY, 32'h0);
            check(q, {24'h0, v[7:0]});
        end
        bus(1'b1, CDPWM_OFS_DUTY, 32'hc0);
        bus(1'b1, CDPWM_OFS_PERIOD, 32'h14);
        // Status is read only, so the write must leave it idle.
        bus(1'b1, CDPWM_OFS_STATUS, 32'hffffffff);
        bus(1'b0, CDPWM_OFS_STATUS, 32'h0);
        check(q[5:0], 32'h0);
        run_mode(1'b1);
        run_mode(1'b0);
        @(posedge clk_sys_i);
        md <= 1'b1;
        @(posedge clk_sys_i);
        en <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        flt_n <= 1'b0;
        md    <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        flt_n <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        bus(1'b0, CDPWM_OFS_STATUS, 32'h0);
        check(q[CDPWM_ST_MODE], 32'h0);
        @(posedge clk_sys_i);
        hot <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        bus(1'b0, CDPWM_OFS_STATUS, 32'h0);
        check(q[CDPWM_ST_RUN], 32'h0);
        hot  <= 1'b0;
        voff <= 1'b0;
        von  <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        voff <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        bus(1'b0, CDPWM_OFS_STATUS, 32'h0);
        check(q[CDPWM_ST_SUPPLY_UNDERVOLTAGE_LOCKOUT], 32'h1);
        von <= 1'b1;
        poll(CDPWM_ST_SUPPLY_UNDERVOLTAGE_LOCKOUT, 1'b0);
        @(posedge clk_sys_i);
        frc <= 1'b1;
        k = 0;
        while (flag_n !== 1'b0 && k < 4000) begin
            @(posedge clk_sys_i);
            k++;
        end
        check(flag_n, 32'h0);
        poll(CDPWM_ST_COOL, 1'b1);
        check({q[CDPWM_ST_SS_LSB +: 8], hs, ls}, 32'h0);
        frc <= 1'b0;
        poll(CDPWM_ST_COOL, 1'b0);
        check(q[CDPWM_ST_SS_LSB +: 8] < 8'h10, 32'h1);
        close_out();
    end
endmodule : cdpwm_core_tb

// ==== test/cdpwm_stage_model.sv ====
`timescale 1ns/1ps
module cdpwm_stage_model #(
    parameter logic [7:0] LIM = 8'h3c
) (
    // Clock and drives
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    input  wire logic hs_i,
    input  wire logic ls_i,
    input  wire logic mode_i,
    input  wire logic force_i,
    // Comparators
    output logic      limit_pos_o,
    output logic      limit_neg_o,
    output logic      zero_current_o
);
    logic [7:0] cur_q;
    // Current rises through the main switch and decays otherwise, so zero is reached.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) cur_q <= 8'h00;
        else if (mode_i ? hs_i : ls_i) cur_q <= cur_q + {7'h0, cur_q != 8'hff};
        else if (cur_q != 8'h00) cur_q <= cur_q - 8'h01;
    end
    assign limit_pos_o    = mode_i & (force_i | (cur_q > LIM));
    assign limit_neg_o    = !mode_i & (force_i | (cur_q > LIM));
    assign zero_current_o = cur_q < 8'h02;
endmodule : cdpwm_stage_model
